/* File: rtl/ipr_pkg.sv */
package ipr_pkg;

	// source and level geometry
	localparam int unsigned NUM_SRC      = 54;
	localparam int unsigned LVL_W        = 3;
	localparam int unsigned NIB_W        = 4;
	localparam int unsigned SRC_PER_REG  = 4;
	localparam int unsigned NUM_PRI_REG  = 14;
	localparam int unsigned SRC_W        = 6;
	localparam int unsigned VEC_W        = 7;
	localparam int unsigned PC_W         = 24;
	localparam int unsigned RST_SRC_N    = 6;

	// vector numbering: source number plus this offset
	localparam logic [VEC_W-1:0] VEC_OFFSET = 7'h08;

	// fixed source numbers of named requests
	localparam int unsigned SRC_EXT_ZERO  = 0;
	localparam int unsigned SRC_PWM_SPEV  = 18;
	localparam int unsigned SRC_PWM_GEN0  = 19;
	localparam int unsigned SRC_ADC_PAIR0 = 37;
	localparam int unsigned NUM_PWM_GEN   = 4;
	localparam int unsigned NUM_ADC_PAIR  = 6;

	// implemented source mask; reserved slots are zero
	localparam logic [NUM_SRC-1:0] SRC_IMPL_MASK =
		54'h0007e1_e87f_7fef;

	// register map, byte addresses
	localparam logic [7:0] ADDR_PRI_BASE  = 8'h00;
	localparam logic [7:0] ADDR_FLAG_LO   = 8'h40;
	localparam logic [7:0] ADDR_FLAG_HI   = 8'h44;
	localparam logic [7:0] ADDR_EN_LO     = 8'h48;
	localparam logic [7:0] ADDR_EN_HI     = 8'h4c;
	localparam logic [7:0] ADDR_RESULT    = 8'h50;
	localparam logic [7:0] ADDR_RST_CAUSE = 8'h54;

	// reset values
	localparam logic [15:0] PRI_RESET     = 16'h4444;
	localparam logic [PC_W-1:0] PC_RESET  = 24'h000000;

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// reset cause bit positions
	typedef enum logic [2:0] {
		RC_WDT,
		RC_UNINIT_W,
		RC_ILLEGAL,
		RC_LOCKOUT,
		RC_EXT,
		RC_POR
	} ipr_rst_cause_t;

	// arbitration result carried to the core
	typedef struct packed {
		logic             req;
		logic [VEC_W-1:0] vec;
		logic [LVL_W-1:0] lvl;
	} ipr_irq_t;

	// core error conditions reported each cycle
	typedef struct packed {
		logic wdt_expired;
		logic uninit_w_ptr;
		logic illegal_exec;
		logic illegal_flushed;
		logic [3:0] trap_hits;
	} ipr_err_t;

endpackage : ipr_pkg

/* File: rtl/ipr_resolver.sv */
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

// Function
// - three-bit level in low nibble bits
// - nibble top bit reads as zero
// - zero lowest level, seven highest
// - natural order breaks same-level ties only
// - source zero best, fifty-three worst
// - source number is natural rank
// - vector equals source plus eight
// - assigned level outranks natural order
// - adc pairs at sources 37 to 42
// - pwm event 18, generators 19 to 22
// - arbitration held idle during reset
// - reset zeroes registers and program counter; priority registers load 4444 instead
// - six error conditions vector to reset
// - watchdog expiry raises reset
// - uninitialized pointer register raises reset
// - executed unused opcode raises reset
// - flushed unused opcode raises nothing
// - simultaneous traps force reset
// - level zero disables source
// - flags set regardless of enable
// - interrupt only above cpu current level
module ipr_resolver
	import ipr_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	input  wire logic              ce_i,
	// raw peripheral events, one per source
	input  wire logic [NUM_SRC-1:0] src_event_i,
	input  wire logic [NUM_PWM_GEN-1:0]  pwm_gen_event_i,
	input  wire logic              pwm_spev_event_i,
	input  wire logic [NUM_ADC_PAIR-1:0] adc_pair_event_i,
	input  wire logic              ext_rst_i,
	input  wire logic              por_i,
	input  wire logic [LVL_W-1:0]  cpu_current_level_i,
	input  wire ipr_err_t          err_i,
	output ipr_irq_t               irq_o,
	output logic [PC_W-1:0]        pc_load_o,
	output logic                   core_rst_o,
	// axi4-lite slave
	input  wire logic [7:0]        s_awaddr,
	input  wire logic              s_awvalid,
	output logic                   s_awready,
	input  wire logic [31:0]       s_wdata,
	input  wire logic [3:0]        s_wstrb,
	input  wire logic              s_wvalid,
	output logic                   s_wready,
	output logic [1:0]             s_bresp,
	output logic                   s_bvalid,
	input  wire logic              s_bready,
	input  wire logic [7:0]        s_araddr,
	input  wire logic              s_arvalid,
	output logic                   s_arready,
	output logic [31:0]            s_rdata,
	output logic [1:0]             s_rresp,
	output logic                   s_rvalid,
	input  wire logic              s_rready
);

	// pending flags, enables, packed levels
	logic [NUM_SRC-1:0]   flag;
	logic [NUM_SRC-1:0]   en;
	logic [15:0]          pri [NUM_PRI_REG];
	logic [RST_SRC_N-1:0] rst_cause;

	// write address/data holding
	logic [7:0]  aw_addr;
	logic        aw_full;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        w_full;
	logic        wr_fire;

	// software clear mask for flags, enable alias, gathered events
	logic [NUM_SRC-1:0] sw_clr;
	logic [NUM_SRC-1:0] sw_set_en;
	logic [NUM_SRC-1:0] ev_all;

	// level of a source from packed nibbles
	function automatic logic [LVL_W-1:0] src_lvl(input int unsigned s);
		src_lvl = pri[s / SRC_PER_REG][(s % SRC_PER_REG) * NIB_W +: LVL_W];
	endfunction : src_lvl

	// apply byte strobes to a 32-bit word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] st);
		merge = old;
		for (int b = 0; b < 4; b++)
			if (st[b])
				merge[b*8 +: 8] = nw[b*8 +: 8];
	endfunction : merge

	// nibble mask so top bit of each never stores
	localparam logic [15:0] NIB_MASK = 16'h7777;

	// gather events; fixed pwm and adc wiring
	always_comb
	begin
		ev_all = src_event_i;
		ev_all[SRC_PWM_SPEV] = pwm_spev_event_i;
		ev_all[SRC_PWM_GEN0 +: NUM_PWM_GEN] = pwm_gen_event_i;
		ev_all[SRC_ADC_PAIR0 +: NUM_ADC_PAIR] = adc_pair_event_i;
		ev_all = ev_all & SRC_IMPL_MASK;
	end

	// write channel acceptance
	assign s_awready = !aw_full;
	assign s_wready  = !w_full;
	assign wr_fire   = aw_full && w_full && !s_bvalid;

	// hold write address
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			aw_full <= 1'b0;
		else if (ce_i)
		begin
			if (s_awvalid && s_awready)
			begin
				aw_full <= 1'b1;
				aw_addr <= s_awaddr;
			end
			else if (wr_fire)
				aw_full <= 1'b0;
		end
	end

	// hold write data
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			w_full <= 1'b0;
		else if (ce_i)
		begin
			if (s_wvalid && s_wready)
			begin
				w_full <= 1'b1;
				w_data <= s_wdata;
				w_strb <= s_wstrb;
			end
			else if (wr_fire)
				w_full <= 1'b0;
		end
	end

	// write response
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			s_bvalid <= 1'b0;
			s_bresp  <= RESP_OKAY;
		end
		else if (ce_i)
		begin
			if (wr_fire)
			begin
				s_bvalid <= 1'b1;
				s_bresp  <= (aw_addr <= ADDR_RST_CAUSE && aw_addr[1:0] == 2'h0
					&& (aw_addr < 8'h38 || aw_addr >= ADDR_FLAG_LO))
					? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_bready)
				s_bvalid <= 1'b0;
		end
	end

	// software clear mask: write one to clear flags
	always_comb
	begin
		sw_clr = '0;
		if (wr_fire && aw_addr == ADDR_FLAG_LO)
			sw_clr[31:0] = merge(32'h0, w_data, w_strb);
		if (wr_fire && aw_addr == ADDR_FLAG_HI)
			sw_clr[NUM_SRC-1:32] =
				(NUM_SRC-32)'(merge(32'h0, w_data, w_strb));
	end

	// sw_set_en unused alias kept to one driver
	assign sw_set_en = en;

	// pending flags: set wins over clear
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			flag <= '0;
		else if (ce_i)
			flag <= ((flag & ~sw_clr) | ev_all) & SRC_IMPL_MASK;
	end

	// enable registers
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			en <= '0;
		else if (ce_i && wr_fire)
		begin
			if (aw_addr == ADDR_EN_LO)
				en[31:0] <= merge(en[31:0], w_data, w_strb);
			if (aw_addr == ADDR_EN_HI)
				en[NUM_SRC-1:32] <= (NUM_SRC-32)'(merge(
					{10'h0, en[NUM_SRC-1:32]}, w_data, w_strb));
		end
	end

	// priority control registers, sixteen bits each
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			for (int r = 0; r < NUM_PRI_REG; r++)
				pri[r] <= PRI_RESET;
		end
		else if (ce_i && wr_fire)
		begin
			for (int r = 0; r < NUM_PRI_REG; r++)
				if (aw_addr == ADDR_PRI_BASE + 8'(r * 4))
					pri[r] <= 16'(merge({16'h0, pri[r]}, w_data,
						{2'b00, w_strb[1:0]})) & NIB_MASK;
		end
	end

	// arbitration: highest level, then lowest source number
	ipr_irq_t next_irq;
	always_comb
	begin
		logic [LVL_W-1:0] best_lvl;
		logic [SRC_W-1:0] best_src;
		logic             found;
		best_lvl = '0;
		best_src = '0;
		found    = 1'b0;
		// ascending scan; strict greater keeps the lower number on ties
		for (int s = 0; s < NUM_SRC; s++)
		begin
			// level zero never competes
			if (flag[s] && en[s] && src_lvl(s) != 3'h0)
			begin
				if (!found || src_lvl(s) > best_lvl)
				begin
					found    = 1'b1;
					best_lvl = src_lvl(s);
					best_src = SRC_W'(s);
				end
			end
		end
		next_irq.lvl = best_lvl;
		next_irq.vec = VEC_W'(best_src) + VEC_OFFSET;
		next_irq.req = found && (best_lvl > cpu_current_level_i);
	end

	// registered request to the core, quiet in reset
	always_ff @(posedge clk_i)
	begin
		if (srst_i || core_rst_o)
			irq_o <= '0;
		else if (ce_i)
			irq_o <= next_irq;
	end

	// synchronise external reset and power-on pins
	logic [1:0] ext_sync;
	logic [1:0] por_sync;
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			ext_sync <= '0;
			por_sync <= '0;
		end
		else if (ce_i)
		begin
			ext_sync <= {ext_sync[0], ext_rst_i};
			por_sync <= {por_sync[0], por_i};
		end
	end

	// error conditions that vector to reset
	logic [RST_SRC_N-1:0] cause_now;
	logic                 lockout;
	assign lockout = err_i.trap_hits[0] + err_i.trap_hits[1]
		+ err_i.trap_hits[2] + err_i.trap_hits[3] > 3'(1);
	always_comb
	begin
		cause_now = '0;
		cause_now[RC_WDT]      = err_i.wdt_expired;
		cause_now[RC_UNINIT_W] = err_i.uninit_w_ptr;
		// only executed opcodes count; flushed ones are ignored
		cause_now[RC_ILLEGAL]  = err_i.illegal_exec;
		cause_now[RC_LOCKOUT]  = lockout;
		cause_now[RC_EXT]      = ext_sync[1];
		cause_now[RC_POR]      = por_sync[1];
	end

	// core reset pulse and sticky cause record
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			core_rst_o <= 1'b0;
			rst_cause  <= '0;
		end
		else if (ce_i)
		begin
			core_rst_o <= |cause_now;
			if (|cause_now)
				rst_cause <= rst_cause | cause_now;
			else if (wr_fire && aw_addr == ADDR_RST_CAUSE)
				rst_cause <= rst_cause & ~w_data[RST_SRC_N-1:0];
		end
	end

	// program counter load value on reset entry
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			pc_load_o <= PC_RESET;
		else if (ce_i && |cause_now)
			pc_load_o <= PC_RESET;
	end

	// read channel
	assign s_arready = !s_rvalid;
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			s_rvalid <= 1'b0;
			s_rdata  <= 32'h0;
			s_rresp  <= RESP_OKAY;
		end
		else if (ce_i)
		begin
			if (s_arvalid && s_arready)
			begin
				s_rvalid <= 1'b1;
				s_rresp  <= RESP_OKAY;
				s_rdata  <= 32'h0;
				if (s_araddr[1:0] != 2'h0)
					s_rresp <= RESP_SLVERR;
				else if (s_araddr < 8'h38)
					s_rdata <= {16'h0, pri[s_araddr[5:2]]};
				else if (s_araddr == ADDR_FLAG_LO)
					s_rdata <= flag[31:0];
				else if (s_araddr == ADDR_FLAG_HI)
					s_rdata <= {10'h0, flag[NUM_SRC-1:32]};
				else if (s_araddr == ADDR_EN_LO)
					s_rdata <= en[31:0];
				else if (s_araddr == ADDR_EN_HI)
					s_rdata <= {10'h0, en[NUM_SRC-1:32]};
				else if (s_araddr == ADDR_RESULT)
					s_rdata <= {21'h0, irq_o.req, irq_o.vec, irq_o.lvl};
				else if (s_araddr == ADDR_RST_CAUSE)
					s_rdata <= {26'h0, rst_cause};
				else
					s_rresp <= RESP_SLVERR;
			end
			else if (s_rready)
				s_rvalid <= 1'b0;
		end
	end

endmodule : ipr_resolver

`default_nettype wire

/* File: verification/ipr_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// watches resolver outputs against their causes
module ipr_monitor
	import ipr_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	input  wire logic             ce_i,
	input  wire logic             ext_rst_i,
	input  wire logic [LVL_W-1:0] cpu_current_level_i,
	input  wire ipr_err_t         err_i,
	input  wire ipr_irq_t         irq_o,
	input  wire logic [PC_W-1:0]  pc_load_o,
	input  wire logic             core_rst_o,
	input  wire logic             s_arvalid,
	input  wire logic             s_arready,
	input  wire logic             s_rvalid,
	input  wire logic             s_rready
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// a core error that must end in reset
	sequence err_cause;
		ce_i && (err_i.wdt_expired || err_i.uninit_w_ptr ||
			err_i.illegal_exec || $countones(err_i.trap_hits) > 1);
	endsequence
	// read address accepted
	sequence ar_taken;
		s_arvalid && s_arready;
	endsequence
	a_vec_range: assert property (irq_o.req |->
		irq_o.vec inside {[7'h08:7'h3d]}) else $error("vector out of range");
	a_no_reserved: assert property (irq_o.req |->
		SRC_IMPL_MASK[irq_o.vec - VEC_OFFSET]) else $error("reserved won");
	a_lvl_nonzero: assert property (irq_o.req |->
		irq_o.lvl != 3'h0) else $error("level zero presented");
	a_above_cpu: assert property (irq_o.req &&
		$stable(cpu_current_level_i) |-> irq_o.lvl > cpu_current_level_i)
		else $error("request not above cpu level");
	a_pc_zero: assert property (pc_load_o == 24'h000000)
		else $error("pc load not zero");
	a_err_reset: assert property (err_cause |=> core_rst_o)
		else $error("error did not reset");
	a_flush_quiet: assert property (
		ce_i && err_i == 8'h10 && !core_rst_o |=> !core_rst_o)
		else $error("flushed opcode reset");
	a_ext_reset: assert property ($rose(ext_rst_i) |->
		##[1:5] core_rst_o) else $error("pin reset lost");
	a_rst_quiet: assert property (disable iff (1'b0)
		srst_i |=> !irq_o.req && !core_rst_o) else $error("busy in reset");
	a_ar_answer: assert property (ar_taken |=> s_rvalid)
		else $error("read not answered");
	a_rdata_hold: assert property (s_rvalid && !s_rready |=> s_rvalid)
		else $error("read data dropped");
endmodule : ipr_monitor
bind ipr_resolver ipr_monitor mon_u (.clk_i, .srst_i, .ce_i, .ext_rst_i,
	.cpu_current_level_i, .err_i, .irq_o, .pc_load_o, .core_rst_o,
	.s_arvalid, .s_arready, .s_rvalid, .s_rready);
`default_nettype wire

/* File: verification/ipr_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// processor core side: level, error flags, fetch
module ipr_core_model
	import ipr_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic [LVL_W-1:0] lvl_i,
	input  wire ipr_err_t         err_i,
	input  wire logic             rst_i,
	input  wire logic [PC_W-1:0]  pc_i,
	output logic [LVL_W-1:0]      cpu_current_level_o,
	output ipr_err_t              err_o,
	output logic [PC_W-1:0]       fetch_o
);
	// level and errors launched on the core clock
	always_ff @(posedge clk_i)
	begin
		cpu_current_level_o <= lvl_i;
		err_o               <= err_i;
	end
	// fetch from reset entry, then step two each cycle
	always_ff @(posedge clk_i)
		fetch_o <= rst_i ? pc_i : fetch_o + 24'h000002;
endmodule : ipr_core_model
`default_nettype wire

/* File: verification/interrupt_priority_resolver_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_resolver_tb_top;
	import ipr_pkg::*;
	logic clk_i, srst_i, ce_i, ext_rst_i, por_i, pwm_spev_event_i;
	logic s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, core_rst_o;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [53:0]      src_event_i;
	logic [3:0]       pwm_gen_event_i, s_wstrb;
	logic [5:0]       adc_pair_event_i;
	logic [2:0]       lvl_req, cpu_current_level_i;
	ipr_err_t         err_req, err_i;
	ipr_irq_t         irq_o;
	logic [23:0]      pc_load_o, fetch;
	logic [7:0]       s_awaddr, s_araddr;
	logic [31:0]      s_wdata, s_rdata, q;
	logic [1:0]       s_bresp, s_rresp, r;
	int               mismatches, n_checks;
	// core partner
	ipr_core_model core_u (.clk_i, .lvl_i(lvl_req), .err_i(err_req),
		.rst_i(core_rst_o), .pc_i(pc_load_o),
		.cpu_current_level_o(cpu_current_level_i), .err_o(err_i),
		.fetch_o(fetch));
	ipr_resolver dut_u (.clk_i, .srst_i, .ce_i, .src_event_i,
		.pwm_gen_event_i, .pwm_spev_event_i, .adc_pair_event_i, .ext_rst_i,
		.por_i, .cpu_current_level_i, .err_i, .irq_o, .pc_load_o,
		.core_rst_o, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
		.s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
		.s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
	// verdict and stop
	task automatic end_sim();
		if (mismatches == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	// value compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// one axi4-lite transfer, channels released as taken
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		logic aw, w, ar, done;
		done = 0;
		s_awaddr <= a;
		s_araddr <= a;
		s_wdata <= d;
		{s_awvalid, s_wvalid, s_bready} <= {3{wr}};
		{s_arvalid, s_rready} <= {2{!wr}};
		for (n = 0; n < 60 && !done; n++)
		begin
			@(negedge clk_i);
			aw = s_awvalid && s_awready;
			w = s_wvalid && s_wready;
			ar = s_arvalid && s_arready;
			q = s_rdata;
			r = wr ? s_bresp : s_rresp;
			done = wr ? s_bvalid : s_rvalid;
			@(posedge clk_i);
			if (aw)
				s_awvalid <= 0;
			if (w)
				s_wvalid <= 0;
			if (ar)
				s_arvalid <= 0;
		end
		{s_bready, s_rready} <= 2'h0;
		@(posedge clk_i);
		if (!done)
		begin
			mismatches++;
			end_sim();
		end
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1, a, d);
	endtask : wr
	// masked register read compare
	task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
		bus(0, a, 32'h0);
		chk(q & m, e);
	endtask : rd
	// clear flags, pulse events, judge the winner
	task automatic fire(input logic [53:0] ev, input logic [6:0] v,
		input logic [2:0] l);
		wr(8'h40, 32'hffffffff);
		wr(8'h44, 32'hffffffff);
		src_event_i <= ev;
		pwm_spev_event_i <= ev[18];
		pwm_gen_event_i <= ev[22:19];
		adc_pair_event_i <= ev[42:37];
		@(posedge clk_i);
		src_event_i <= '0;
		pwm_spev_event_i <= 0;
		pwm_gen_event_i <= '0;
		adc_pair_event_i <= '0;
		repeat (4) @(posedge clk_i);
		if (v == 7'h00)
			chk(32'(irq_o.req), 32'h0);
		else
			chk(32'(irq_o), {21'h0, 1'b1, v, l});
	endtask : fire
	// register reset value, unused bit, unmapped place
	task automatic t_regs();
		rd(8'h00, 32'hffffffff, 32'h00004444);
		wr(8'h34, 32'hffffffff);
		rd(8'h34, 32'hffffffff, 32'h00007777);
		rd(8'h80, 32'hffffffff, 32'h0);
		chk(32'(r), 32'(RESP_SLVERR));
		wr(8'h34, 32'h00004444);
	endtask : t_regs
	// ranking, fixed numbering, masking
	task automatic t_rank();
		int i;
		int s [14] = '{0, 18, 19, 20, 21, 22, 27, 32,
			37, 38, 39, 40, 41, 42};
		wr(8'h48, 32'hffffffff);
		wr(8'h4c, 32'hffffffff);
		fire(54'h0a, 7'h09, 3'h4);
		fire(54'h10, 7'h00, 3'h0);
		for (i = 0; i < 14; i++)
			fire(54'h1 << s[i], 7'(s[i] + 8), 3'h4);
		wr(8'h00, 32'h00000071);
		fire(54'h7, 7'h09, 3'h7);
		fire(54'h4, 7'h00, 3'h0);
		lvl_req <= 3'h4;
		wr(8'h00, 32'h00004444);
		fire(54'h2, 7'h00, 3'h0);
		wr(8'h00, 32'h00000050);
		fire(54'h2, 7'h09, 3'h5);
		lvl_req <= 3'h0;
		wr(8'h48, 32'h0);
		fire(54'h2, 7'h00, 3'h0);
		rd(8'h40, 32'h2, 32'h2);
		wr(8'h48, 32'hffffffff);
	endtask : t_rank
	// clock enable low: an event while frozen leaves no flag
	task automatic t_freeze();
		wr(8'h40, 32'hffffffff);
		ce_i <= 0;
		src_event_i <= 54'h2;
		repeat (4) @(posedge clk_i);
		src_event_i <= '0;
		ce_i <= 1;
		repeat (4) @(posedge clk_i);
		chk(32'(irq_o.req), 32'h0);
		rd(8'h40, 32'h2, 32'h0);
	endtask : t_freeze
	// one reset cause, pulse then look for reset and cause bit
	task automatic rc(input ipr_err_t e, input logic [1:0] x,
		input logic [5:0] exp);
		int n;
		logic seen;
		seen = 0;
		wr(8'h54, 32'h3f);
		err_req <= e;
		{por_i, ext_rst_i} <= x;
		@(posedge clk_i);
		err_req <= '0;
		{por_i, ext_rst_i} <= 2'h0;
		for (n = 0; n < 8; n++)
		begin
			@(negedge clk_i);
			seen |= core_rst_o;
		end
		@(posedge clk_i);
		chk(32'(seen), 32'(exp != 6'h00));
		rd(8'h54, 32'h3f, 32'(exp));
	endtask : rc
	task automatic t_reset();
		rc(8'h80, 2'h0, 6'h01);
		rc(8'h40, 2'h0, 6'h02);
		rc(8'h20, 2'h0, 6'h04);
		rc(8'h10, 2'h0, 6'h00);
		rc(8'h03, 2'h0, 6'h08);
		rc(8'h01, 2'h0, 6'h00);
		rc(8'h00, 2'h1, 6'h10);
		rc(8'h00, 2'h2, 6'h20);
	endtask : t_reset
	// free running clock
	initial
	begin
		clk_i = 0;
		forever #2 clk_i = ~clk_i;
	end
	// main sequence
	initial
	begin
		{srst_i, ce_i, s_wstrb} = 6'h3f;
		{ext_rst_i, por_i, pwm_spev_event_i} = 3'h0;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
		{src_event_i, pwm_gen_event_i, adc_pair_event_i} = '0;
		{lvl_req, err_req, s_awaddr, s_araddr, s_wdata} = '0;
		repeat (20) @(posedge clk_i);
		srst_i <= 0;
		@(posedge clk_i);
		t_regs();
		t_rank();
		t_freeze();
		t_reset();
		end_sim();
	end
endmodule : interrupt_priority_resolver_tb_top
`default_nettype wire
